// file: inc/acr_defines.svh
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH

// word and counter widths
`define ACR_WORD_BITS    24
`define ACR_CNT_W        5
`define ACR_CAL_W        16
`define ACR_SYNC_BITS    5

// serial word lengths in clock pulses
`define ACR_LONG_LEN     5'h18
`define ACR_SHORT_LEN    5'h10

// control word layout, msb first
`define ACR_MODE_MSB     23
`define ACR_MODE_LSB     21
`define ACR_GAIN_MSB     20
`define ACR_GAIN_LSB     18
`define ACR_CHAN_BIT     17
`define ACR_PDOWN_BIT    16
`define ACR_OLEN_BIT     15
`define ACR_COMP_BIT     14
`define ACR_BURN_BIT     13
`define ACR_UNIPOLAR_BIT 12
`define ACR_FILT_MSB     11
`define ACR_FILT_LSB     0
`define ACR_CTRL_RESET   24'h000000

// mode field codes
`define ACR_MODE_NORMAL  3'h0
`define ACR_MODE_SELF    3'h1
`define ACR_MODE_SYSZERO 3'h2
`define ACR_MODE_SYSFULL 3'h3

// default length of one calibration phase in ref_clk cycles
`define ACR_CAL_PHASE_DEF 16'h0100

`endif

// file: inc/acr_pkg.sv
`include "acr_defines.svh"

package acr_pkg;

  typedef enum logic [1:0] {LK_IDLE, LK_WRITE, LK_READ, LK_DRAIN} acr_link_t;
  typedef enum logic [1:0] {CAL_IDLE, CAL_ZERO, CAL_FULL} acr_cal_t;

  typedef struct packed {
    logic [`ACR_WORD_BITS-1:0] ctrlWord;
    logic [`ACR_WORD_BITS-1:0] shiftIn;
    logic [`ACR_WORD_BITS-1:0] shiftOut;
    logic [`ACR_CNT_W-1:0]     bitCnt;
    logic [`ACR_CNT_W-1:0]     bitLen;
    logic                      serClkPrev;
    logic                      readData;
    logic                      calSelf;
    logic                      calDone;
    acr_link_t                 link;
    acr_cal_t                  cal;
    logic [`ACR_CAL_W-1:0]     calCnt;
    logic                      drdyN;
    logic                      sdOut;
    logic                      sdOe;
    logic                      calZero;
    logic                      calFull;
    logic                      calInput;
  } acr_ctrl_t;

endpackage : acr_pkg

// file: hdl/acr_sync.sv
`timescale 1ns/10ps
`default_nettype none

module acr_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstN,
  // levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] held;
  } acr_sync_t;

  acr_sync_t s_reg;
  acr_sync_t s_next;

  always_comb begin
    s_next.meta = d;
    s_next.held = s_reg.meta;
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.held;

endmodule : acr_sync

`default_nettype wire

// file: hdl/acr_buf2.sv
`timescale 1ns/10ps
`default_nettype none

module acr_buf2 #(
  parameter int WIDTH = 24
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstN,
  // fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // drain side
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);

  typedef struct packed {
    logic [WIDTH-1:0] head;
    logic [WIDTH-1:0] tail;
    logic [1:0]       cnt;
    logic             rdy;
  } acr_buf_t;

  acr_buf_t s_reg;
  acr_buf_t s_next;
  logic     push;
  logic     pop;
  logic [1:0] fill;

  always_comb begin
    s_next = s_reg;
    pop    = outReady && (s_reg.cnt != 2'h0);
    push   = inValid && s_reg.rdy;
    fill   = s_reg.cnt;
    if (pop) begin
      s_next.head = s_reg.tail;
      fill        = s_reg.cnt - 2'h1;
    end
    if (push) begin
      if (fill == 2'h0) begin
        s_next.head = inData;
      end else begin
        s_next.tail = inData;
      end
      fill = fill + 2'h1;
    end
    s_next.cnt = fill;
    // a registered ready so that a full buffer stalls the source
    s_next.rdy = (fill != 2'h2);
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s_reg     <= '0;
      s_reg.rdy <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign inReady  = s_reg.rdy;
  assign outValid = (s_reg.cnt != 2'h0);
  assign outData  = s_reg.head;

endmodule : acr_buf2

`default_nettype wire

// file: hdl/acr_control.sv
`timescale 1ns/10ps
`default_nettype none
`include "acr_defines.svh"

// Operation
// - a completed write frame with register select low goes to the control word.
// - a read frame with register select low shifts out the current control word.
// - the control word loads only after 24 bits arrive; a shorter write is discarded.
// - serial clock pulses after the 24th in a write frame are ignored.
// - the control word is 24 bits msb first: mode, gain, flags high, filter code low.
// - mode code zero is normal mode, where data reads return conversion words; reset value.
// - mode 001 runs self calibration, zero scale on shorted inputs then full scale on reference.
// - at the end of self calibration the mode field returns to zero and conversion resumes.
// - mode 010 runs a zero-scale calibration on the input, flags completion, then normal mode.
// - mode 011 runs a full-scale calibration on the input, flags completion, then normal mode.
// - data-ready falls when a word or calibration result is ready, rises after a full data read.
// - results are natural binary when unipolar and offset binary when bipolar.

module acr_control
  import acr_pkg::*;
#(
  parameter logic [`ACR_CAL_W-1:0] CAL_PHASE_CYCLES = `ACR_CAL_PHASE_DEF
) (
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      nrst,
  // serial port
  input  wire logic                      serialClock,
  input  wire logic                      transmit_frame_sync_n,
  input  wire logic                      receive_frame_sync_n,
  input  wire logic                      register_select_pin,
  input  wire logic                      serial_data_line_in,
  output logic                           serial_data_line_out,
  output logic                           serial_data_line_oe,
  output logic                           result_ready_n,
  // filter results
  input  wire logic [`ACR_WORD_BITS-1:0] sampleData,
  input  wire logic                      sampleValid,
  output logic                           sampleReady,
  // converter control
  output logic      [`ACR_WORD_BITS-1:0] controlWord,
  output logic                           calZeroActive,
  output logic                           calFullActive,
  output logic                           calOnInput
);

  ////////////////////////////////////////////////////////////////////////////
  acr_ctrl_t s_reg;
  acr_ctrl_t s_next;
  logic      rstN;
  logic      serClkS;
  logic      txFrameS;
  logic      rxFrameS;
  logic      selS;
  logic      dataS;
  logic [1:0] frameLow;
  logic      rise;
  logic      fall;
  logic      loadCtrl;
  logic      pop;
  logic      calLast;
  logic      modeNormal;
  logic      convOn;
  logic      bufValid;
  logic [`ACR_WORD_BITS-1:0] bufData;
  logic [`ACR_WORD_BITS-1:0] newWord;
  logic [`ACR_WORD_BITS-1:0] coded;

  function automatic logic [`ACR_WORD_BITS-1:0] codeSample(
    input logic [`ACR_WORD_BITS-1:0] raw,
    input logic                      unipolar
  );
    if (unipolar) begin
      // negative unipolar readings clip to zero
      codeSample = raw[`ACR_WORD_BITS-1] ? '0 : {raw[`ACR_WORD_BITS-2:0], 1'b0};
    end else begin
      codeSample = {~raw[`ACR_WORD_BITS-1], raw[`ACR_WORD_BITS-2:0]};
    end
  endfunction : codeSample

  ////////////////////////////////////////////////////////////////////////////
  acr_sync #(.WIDTH(1)) rstSync (
    .clk  (ref_clk),
    .rstN (nrst),
    .d    (1'b1),
    .q    (rstN)
  );

  // frames pass inverted so that the synchroniser's reset value reads as idle
  acr_sync #(.WIDTH(`ACR_SYNC_BITS)) pinSync (
    .clk  (ref_clk),
    .rstN (rstN),
    .d    ({serialClock, ~transmit_frame_sync_n, ~receive_frame_sync_n,
            register_select_pin, serial_data_line_in}),
    .q    ({serClkS, frameLow, selS, dataS})
  );

  assign coded = codeSample(sampleData, s_reg.ctrlWord[`ACR_UNIPOLAR_BIT]);

  acr_buf2 #(.WIDTH(`ACR_WORD_BITS)) resultBuf (
    .clk      (ref_clk),
    .rstN     (rstN),
    .inValid  (sampleValid && convOn),
    .inData   (coded),
    .inReady  (sampleReady),
    .outValid (bufValid),
    .outData  (bufData),
    .outReady (pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign rise       = serClkS && !s_reg.serClkPrev;
  assign fall       = !serClkS && s_reg.serClkPrev;
  assign txFrameS   = !frameLow[1];
  assign rxFrameS   = !frameLow[0];
  assign calLast    = (s_reg.calCnt == CAL_PHASE_CYCLES - 16'h0001);
  assign modeNormal = (s_reg.ctrlWord[`ACR_MODE_MSB:`ACR_MODE_LSB] == `ACR_MODE_NORMAL);
  assign convOn     = modeNormal && (s_reg.cal == CAL_IDLE)
                      && !s_reg.ctrlWord[`ACR_PDOWN_BIT];
  assign newWord    = {s_reg.shiftIn[`ACR_WORD_BITS-2:0], dataS};

  always_comb begin
    s_next            = s_reg;
    s_next.serClkPrev = serClkS;
    loadCtrl          = 1'b0;
    pop               = 1'b0;
    // serial frames
    case (s_reg.link)
      LK_IDLE: begin
        s_next.bitCnt = '0;
        if (!txFrameS) begin
          s_next.link = LK_WRITE;
        end else if (!rxFrameS) begin
          if (!selS) begin
            s_next.shiftOut = s_reg.ctrlWord;
            s_next.bitLen   = `ACR_LONG_LEN;
            s_next.readData = 1'b0;
            s_next.sdOe     = 1'b1;
            s_next.sdOut    = s_reg.ctrlWord[`ACR_WORD_BITS-1];
            s_next.link     = LK_READ;
          end else if (modeNormal && bufValid) begin
            s_next.shiftOut = bufData;
            s_next.bitLen   = s_reg.ctrlWord[`ACR_OLEN_BIT] ? `ACR_LONG_LEN : `ACR_SHORT_LEN;
            s_next.readData = 1'b1;
            s_next.sdOe     = 1'b1;
            s_next.sdOut    = bufData[`ACR_WORD_BITS-1];
            s_next.link     = LK_READ;
          end else begin
            s_next.link = LK_DRAIN;
          end
        end
      end
      LK_WRITE: begin
        if (txFrameS) begin
          s_next.link = LK_IDLE;
        end else if (rise && (s_reg.bitCnt != `ACR_LONG_LEN)) begin
          s_next.shiftIn = newWord;
          s_next.bitCnt  = s_reg.bitCnt + 5'h01;
          if ((s_reg.bitCnt == `ACR_LONG_LEN - 5'h01) && !selS) begin
            loadCtrl = 1'b1;
          end
        end
      end
      LK_READ: begin
        if (rxFrameS) begin
          s_next.sdOe = 1'b0;
          s_next.link = LK_IDLE;
        end else if (rise) begin
          s_next.bitCnt = s_reg.bitCnt + 5'h01;
          if (s_reg.bitCnt == s_reg.bitLen - 5'h01) begin
            s_next.sdOe = 1'b0;
            pop         = s_reg.readData;
            s_next.link = LK_DRAIN;
          end
        end else if (fall) begin
          s_next.shiftOut = {s_reg.shiftOut[`ACR_WORD_BITS-2:0], 1'b0};
          s_next.sdOut    = s_reg.shiftOut[`ACR_WORD_BITS-2];
        end
      end
      LK_DRAIN: begin
        if (txFrameS && rxFrameS) begin
          s_next.link = LK_IDLE;
        end
      end
      default: begin
        s_next.link = LK_IDLE;
      end
    endcase
    // a finished data read clears a calibration flag; a calibration end below wins
    if (pop) begin
      s_next.calDone = 1'b0;
    end
    // calibration sequencing
    case (s_reg.cal)
      CAL_IDLE: begin
        s_next.calCnt = '0;
      end
      CAL_ZERO: begin
        s_next.calCnt = s_reg.calCnt + 16'h0001;
        if (calLast) begin
          s_next.calCnt  = '0;
          s_next.calZero = 1'b0;
          if (s_reg.calSelf) begin
            s_next.cal     = CAL_FULL;
            s_next.calFull = 1'b1;
          end else begin
            s_next.cal      = CAL_IDLE;
            s_next.calInput = 1'b0;
            s_next.calDone  = 1'b1;
            s_next.ctrlWord[`ACR_MODE_MSB:`ACR_MODE_LSB] = `ACR_MODE_NORMAL;
          end
        end
      end
      CAL_FULL: begin
        s_next.calCnt = s_reg.calCnt + 16'h0001;
        if (calLast) begin
          s_next.cal      = CAL_IDLE;
          s_next.calFull  = 1'b0;
          s_next.calInput = 1'b0;
          s_next.calDone  = 1'b1;
          s_next.ctrlWord[`ACR_MODE_MSB:`ACR_MODE_LSB] = `ACR_MODE_NORMAL;
        end
      end
      default: begin
        s_next.cal = CAL_IDLE;
      end
    endcase
    // a fresh control word restarts whatever sequence was running
    if (loadCtrl) begin
      s_next.ctrlWord = newWord;
      s_next.calDone  = 1'b0;
      s_next.calCnt   = '0;
      s_next.calSelf  = 1'b0;
      s_next.calZero  = 1'b0;
      s_next.calFull  = 1'b0;
      s_next.calInput = 1'b0;
      s_next.cal      = CAL_IDLE;
      case (newWord[`ACR_MODE_MSB:`ACR_MODE_LSB])
        `ACR_MODE_SELF: begin
          s_next.cal     = CAL_ZERO;
          s_next.calSelf = 1'b1;
          s_next.calZero = 1'b1;
        end
        `ACR_MODE_SYSZERO: begin
          s_next.cal      = CAL_ZERO;
          s_next.calZero  = 1'b1;
          s_next.calInput = 1'b1;
        end
        `ACR_MODE_SYSFULL: begin
          s_next.cal      = CAL_FULL;
          s_next.calFull  = 1'b1;
          s_next.calInput = 1'b1;
        end
        default: begin
          s_next.cal = CAL_IDLE;
        end
      endcase
    end
    // data-ready goes high after each finished data read, for one cycle only if a word or calibration flag remains
    s_next.drdyN = pop || !(bufValid || s_reg.calDone);
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      s_reg          <= '0;
      s_reg.ctrlWord <= `ACR_CTRL_RESET;
      s_reg.drdyN    <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign serial_data_line_out = s_reg.sdOut;
  assign serial_data_line_oe  = s_reg.sdOe;
  assign result_ready_n       = s_reg.drdyN;
  assign controlWord          = s_reg.ctrlWord;
  assign calZeroActive        = s_reg.calZero;
  assign calFullActive        = s_reg.calFull;
  assign calOnInput           = s_reg.calInput;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstN);

  property p_loadFilter;
    (s_reg.link == LK_WRITE && !txFrameS && rise && !selS
     && s_reg.bitCnt == `ACR_LONG_LEN - 5'h01)
    |=> s_reg.ctrlWord[`ACR_FILT_MSB:`ACR_FILT_LSB]
        == $past(newWord[`ACR_FILT_MSB:`ACR_FILT_LSB]);
  endproperty
  a_loadFilter: assert property (p_loadFilter)
    else $error("control word not loaded from completed write");
  property p_partialDrop;
    (s_reg.link == LK_WRITE && txFrameS) |=> $stable(s_reg.ctrlWord[`ACR_FILT_MSB:0]);
  endproperty
  a_partialDrop: assert property (p_partialDrop)
    else $error("partial write changed the control word");
  property p_extraPulses;
    (s_reg.link == LK_WRITE && s_reg.bitCnt == `ACR_LONG_LEN)
    |=> $stable(s_reg.shiftIn) && s_reg.bitCnt == `ACR_LONG_LEN;
  endproperty
  a_extraPulses: assert property (p_extraPulses)
    else $error("pulse after the last bit was taken");
  property p_readCtrl;
    (s_reg.link == LK_IDLE && txFrameS && !rxFrameS && !selS)
    |=> s_reg.sdOe && s_reg.bitLen == `ACR_LONG_LEN
        && s_reg.shiftOut[`ACR_GAIN_MSB:0] == $past(s_reg.ctrlWord[`ACR_GAIN_MSB:0]);
  endproperty
  a_readCtrl: assert property (p_readCtrl)
    else $error("control word read did not start");
  property p_dataOnlyNormal;
    (s_reg.link == LK_IDLE && txFrameS && !rxFrameS && selS && !modeNormal)
    |=> !s_reg.sdOe ##1 !s_reg.sdOe;
  endproperty
  a_dataOnlyNormal: assert property (p_dataOnlyNormal)
    else $error("data read outside normal mode");
  property p_selfSteps;
    (s_reg.cal == CAL_ZERO && s_reg.calSelf && calLast && !loadCtrl)
    |=> s_reg.cal == CAL_FULL && s_reg.calFull && !s_reg.calInput;
  endproperty
  a_selfSteps: assert property (p_selfSteps)
    else $error("self calibration skipped its full-scale step");

  property p_calFinish;
    (s_reg.cal != CAL_IDLE && calLast && !loadCtrl
     && (s_reg.cal == CAL_FULL || !s_reg.calSelf))
    |=> modeNormal && s_reg.cal == CAL_IDLE ##1 !s_reg.drdyN;
  endproperty
  a_calFinish: assert property (p_calFinish)
    else $error("calibration end did not restore normal mode");

  property p_readyHigh;
    (s_reg.link == LK_READ && !rxFrameS && rise && s_reg.readData
     && s_reg.bitCnt == s_reg.bitLen - 5'h01)
    |=> s_reg.drdyN && !s_reg.sdOe;
  endproperty
  a_readyHigh: assert property (p_readyHigh)
    else $error("data-ready did not rise after a full word");

  property p_bipolarCode;
    (!s_reg.ctrlWord[`ACR_UNIPOLAR_BIT]) |-> coded[`ACR_WORD_BITS-1] != sampleData[`ACR_WORD_BITS-1];
  endproperty
  a_bipolarCode: assert property (p_bipolarCode)
    else $error("bipolar result not offset binary");

endmodule : acr_control

`default_nettype wire

// file: dv/acr_host_model.sv
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module acr_host_model (
  // clock
  input  wire logic ref_clk,
  // serial port
  output logic      serialClock,
  output logic      transmit_frame_sync_n,
  output logic      receive_frame_sync_n,
  output logic      register_select_pin,
  output logic      hostData,
  output logic      hostDataOe,
  input  wire logic lineLevel
);

  initial begin
    serialClock           = 1'b0;
    transmit_frame_sync_n = 1'b1;
    receive_frame_sync_n  = 1'b1;
    register_select_pin   = 1'b0;
    hostData              = 1'b0;
    hostDataOe            = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  ////////////////////////////////////////////////////////////////////////////////
  // write frame: clock idles low outside frames, data set up before each rise
  task automatic writeFrame(input logic sel, input logic [23:0] word, input int nBits);
    register_select_pin   = sel;
    transmit_frame_sync_n = 1'b0;
    hostDataOe            = 1'b1;
    cyc(4);
    for (int i = 0; i < nBits; i++) begin
      // bits past the word are junk that must be ignored
      hostData = (i < 24) ? word[23-i] : ~hostData;
      cyc(4);
      serialClock = 1'b1;
      cyc(4);
      serialClock = 1'b0;
    end
    cyc(4);
    transmit_frame_sync_n = 1'b1;
    hostDataOe            = 1'b0;
    cyc(4);
  endtask : writeFrame

  ////////////////////////////////////////////////////////////////////////////////
  // read frame: sample on each rising edge, long low phase covers the shift delay
  task automatic readFrame(input logic sel, input int nBits, output logic [23:0] word);
    word                 = 24'h000000;
    register_select_pin  = sel;
    receive_frame_sync_n = 1'b0;
    cyc(6);
    for (int i = 0; i < nBits; i++) begin
      serialClock = 1'b1;
      word        = {word[22:0], lineLevel};
      cyc(3);
      serialClock = 1'b0;
      cyc(5);
    end
    receive_frame_sync_n = 1'b1;
    cyc(4);
  endtask : readFrame

endmodule : acr_host_model

`default_nettype wire

// file: dv/adc_control_register_mode_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "acr_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module adc_control_register_mode_test;

  typedef struct {
    logic        sel;
    logic [23:0] word;
    int          nBits;
    logic [23:0] wantWord;
  } acr_row_t;

  logic        ref_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic        serialClock, transmit_frame_sync_n, receive_frame_sync_n, register_select_pin;
  logic        hostData, hostDataOe, dataOut, dataOe, lineLevel;
  logic        lastLevel = 1'b0;
  logic        result_ready_n, sampleValid, sampleReady;
  logic        calZeroActive, calFullActive, calOnInput, seenZero, seenFull;
  logic [23:0] sampleData, controlWord, r;
  int          errors, comparisons;

  acr_row_t rows [5] = '{
    '{1'b0, 24'h1a2b3c, 24, 24'h1a2b3c},
    '{1'b0, 24'h0f0f0f, 12, 24'h1a2b3c},
    '{1'b0, 24'h055aa5, 26, 24'h055aa5},
    '{1'b1, 24'h0c0ffe, 24, 24'h055aa5},
    '{1'b0, 24'ha53c7e, 24, 24'ha53c7e}
  };

  always #4 ref_clk = ~ref_clk;

  // undriven data line toggles so a stale value never reads as valid
  always_comb lineLevel = dataOe ? dataOut : (hostDataOe ? hostData : ~lastLevel);
  always @(posedge ref_clk) lastLevel <= lineLevel;

  acr_host_model u_host (
    .ref_clk               (ref_clk),
    .serialClock           (serialClock),
    .transmit_frame_sync_n (transmit_frame_sync_n),
    .receive_frame_sync_n  (receive_frame_sync_n),
    .register_select_pin   (register_select_pin),
    .hostData              (hostData),
    .hostDataOe            (hostDataOe),
    .lineLevel             (lineLevel)
  );

  acr_control #(.CAL_PHASE_CYCLES(16'h0040)) u_dut (
    .ref_clk               (ref_clk),
    .nrst                  (nrst),
    .serialClock           (serialClock),
    .transmit_frame_sync_n (transmit_frame_sync_n),
    .receive_frame_sync_n  (receive_frame_sync_n),
    .register_select_pin   (register_select_pin),
    .serial_data_line_in   (lineLevel),
    .serial_data_line_out  (dataOut),
    .serial_data_line_oe   (dataOe),
    .result_ready_n        (result_ready_n),
    .sampleData            (sampleData),
    .sampleValid           (sampleValid),
    .sampleReady           (sampleReady),
    .controlWord           (controlWord),
    .calZeroActive         (calZeroActive),
    .calFullActive         (calFullActive),
    .calOnInput            (calOnInput)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] want);
    comparisons++;
    if (seen !== want) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, want, seen);
    end
  endtask : check

  task automatic conclude;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  // valid held until an edge that sees ready high
  task automatic push(input logic [23:0] raw);
    logic rdy;
    rdy         = 1'b0;
    sampleData  = raw;
    sampleValid = 1'b1;
    for (int i = 0; i < 400 && !rdy; i++) begin
      rdy = sampleReady;
      cyc(1);
    end
    sampleValid = 1'b0;
    check("push accepted", 24'(rdy), 24'h1);
    cyc(1);
  endtask : push

  function automatic logic [23:0] coded(input logic [23:0] raw, input logic uni);
    if (!uni) begin
      return raw ^ 24'h800000;
    end
    return raw[23] ? 24'h000000 : {raw[22:0], 1'b0};
  endfunction : coded

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    errors++;
    conclude();
  end

  initial begin
    sampleValid = 1'b0;
    sampleData  = 24'h000000;
    errors      = 0;
    comparisons = 0;
    cyc(2);
    nrst = 1'b1;
    cyc(4);
    check("controlWord reset", controlWord, `ACR_CTRL_RESET);
    check("result_ready_n reset", 24'(result_ready_n), 24'h1);
    check("sampleReady reset", 24'(sampleReady), 24'h1);
    check("data oe reset", 24'(dataOe), 24'h0);
    foreach (rows[i]) begin
      u_host.writeFrame(rows[i].sel, rows[i].word, rows[i].nBits);
      check("controlWord", controlWord, rows[i].wantWord);
      u_host.readFrame(1'b0, 24, r);
      check("control readback", r, rows[i].wantWord);
    end
    // calibration modes 1..3
    for (int m = 1; m < 4; m++) begin
      u_host.writeFrame(1'b0, {m[2:0], 21'h0000a5}, 24);
      check("ready cleared by write", 24'(result_ready_n), 24'h1);
      check("calOnInput", 24'(calOnInput), 24'(m != 1));
      seenZero = calZeroActive;
      seenFull = calFullActive;
      for (int i = 0; i < 400 && result_ready_n !== 1'b0; i++) begin
        cyc(1);
        seenZero |= calZeroActive;
        seenFull |= calFullActive;
      end
      check("zero phase run", 24'(seenZero), 24'(m != 3));
      check("full phase run", 24'(seenFull), 24'(m != 2));
      check("cal done ready", 24'(result_ready_n), 24'h0);
      check("mode cleared", controlWord, 24'h0000a5);
    end
    // fill the buffer, then read with a stalled word waiting
    u_host.writeFrame(1'b0, 24'h000000, 24);
    push(24'h123456);
    push(24'hfedcba);
    cyc(2);
    check("sampleReady full", 24'(sampleReady), 24'h0);
    check("ready with words", 24'(result_ready_n), 24'h0);
    fork
      push(24'h800001);
      u_host.readFrame(1'b1, 16, r);
    join
    check("data word 1", r, 24'(coded(24'h123456, 1'b0) >> 8));
    u_host.readFrame(1'b1, 16, r);
    check("data word 2", r, 24'(coded(24'hfedcba, 1'b0) >> 8));
    u_host.readFrame(1'b1, 16, r);
    check("data word 3", r, 24'(coded(24'h800001, 1'b0) >> 8));
    cyc(2);
    check("ready after drain", 24'(result_ready_n), 24'h1);
    // unipolar, 24-bit words
    u_host.writeFrame(1'b0, 24'h009000, 24);
    push(24'h123456);
    push(24'hf00000);
    u_host.readFrame(1'b1, 24, r);
    check("unipolar positive", r, coded(24'h123456, 1'b1));
    u_host.readFrame(1'b1, 24, r);
    check("unipolar negative", r, coded(24'hf00000, 1'b1));
    // power-down drops filter words
    u_host.writeFrame(1'b0, 24'h010000, 24);
    push(24'h111111);
    cyc(2);
    check("ready in power-down", 24'(result_ready_n), 24'h1);
    // reset in mid-run
    nrst = 1'b0;
    cyc(2);
    check("controlWord rereset", controlWord, `ACR_CTRL_RESET);
    nrst = 1'b1;
    cyc(4);
    check("ready after rereset", 24'(result_ready_n), 24'h1);
    check("mode after rereset", controlWord, `ACR_CTRL_RESET);
    u_host.writeFrame(1'b0, 24'h1c5a96, 24);
    check("write after rereset", controlWord, 24'h1c5a96);
    conclude();
  end

endmodule : adc_control_register_mode_test

`default_nettype wire
